// ==== design/tdm_host_pkg.sv ====
// Constants, field positions and state type for the time-slot switch host port.
// Assumes one 25 MHz system clock; every host pin is asynchronous to it.
package tdm_host_pkg;

  // ----------------------------------------------------------------
  // Channel plan
  // ----------------------------------------------------------------
  localparam int CHAN_BACKPLANE = 384 - 128;
  localparam int CHAN_LOCAL = 128;
  localparam int CHAN_TOTAL = CHAN_BACKPLANE + CHAN_LOCAL;
  localparam int SAMPLE_BITS = 8;
  localparam int SAMPLE_RATE_KHZ = 8;
  localparam int CHAN_RATE_KBPS = SAMPLE_BITS * SAMPLE_RATE_KHZ;
  localparam int PTR_BITS = 9;
  localparam int CM_BITS = 12;
  localparam int CM_LOW_BITS = 8;
  localparam int CM_HIGH_BITS = CM_BITS - CM_LOW_BITS;
  localparam int DMA_CH = 2;

  // ----------------------------------------------------------------
  // Host register indices and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_ADDR_LO = 8'h00;
  localparam logic [7:0] REG_ADDR_HI = 8'h01;
  localparam logic [7:0] REG_MEM_DATA = 8'h02;
  localparam logic [7:0] REG_CTRL = 8'h03;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int HI_PTR8 = 0;
  localparam int HI_SEL_CM = 1;
  localparam int HI_CM_HIGH = 2;
  localparam int HI_BITS = 3;
  localparam int CTRL_DMA_EN = 0;
  localparam int CTRL_OVERRUN = 1;
  localparam int CTRL_CLK_LOST = 2;
  localparam int CTRL_PLL_UNLOCK = 3;
  localparam int CTRL_MUX = 4;

  // ----------------------------------------------------------------
  // Packed pin vector for the synchroniser
  // ----------------------------------------------------------------
  localparam int PIN_BITS = 16;
  localparam int P_AD = 8;
  localparam int P_A = 6;
  localparam int P_ALE = 5;
  localparam int P_CS = 4;
  localparam int P_RD = 3;
  localparam int P_WR = 2;
  localparam int P_DACK = 0;
  localparam logic [PIN_BITS-1:0] PIN_IDLE = 16'h001c;

  typedef enum {ST_IDLE, ST_FETCH, ST_HOLD} port_state_type;

endpackage : tdm_host_pkg

// ==== design/tdm_switch_host_port.sv ====
// Host microprocessor port of the time-slot switch, with both memories.
// Assumes host pins are asynchronous to CLK and the switching fabric runs on CLK.
`timescale 1ns/10ps

module tdm_switch_host_port #(
  parameter int DEPTH = tdm_host_pkg::CHAN_TOTAL
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Host bus pins
  input wire logic [7:0] AD_IN,
  output logic [7:0] AD_OUT,
  output logic AD_OE,
  input wire logic [1:0] ADDR_PIN,
  input wire logic ALE,
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  output logic READY_OUT,
  output logic READY_OE,
  // Status and DMA pins
  output logic ERR,
  output logic [tdm_host_pkg::DMA_CH-1:0] DMA_TRANSFER_REQUEST,
  input wire logic [tdm_host_pkg::DMA_CH-1:0] DMA_GRANT_ACK,
  // Fabric status and DMA needs
  input wire logic CLK4_LOST,
  input wire logic PLL_UNLOCKED,
  input wire logic [tdm_host_pkg::DMA_CH-1:0] DMA_NEED,
  // Fabric memory ports
  input wire logic SW_DM_WE,
  input wire logic [tdm_host_pkg::PTR_BITS-1:0] SW_DM_WADDR,
  input wire logic [tdm_host_pkg::SAMPLE_BITS-1:0] SW_DM_WDATA,
  input wire logic [tdm_host_pkg::PTR_BITS-1:0] SW_DM_RADDR,
  input wire logic [tdm_host_pkg::PTR_BITS-1:0] SW_CM_RADDR,
  output logic [tdm_host_pkg::SAMPLE_BITS-1:0] SW_DM_Q,
  output logic [tdm_host_pkg::CM_BITS-1:0] SW_CM_Q
);
  import tdm_host_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Memories carry no reset so a chip reset leaves connections intact
  logic [SAMPLE_BITS-1:0] dm [DEPTH];
  logic [CM_BITS-1:0] cm [DEPTH];

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] idx);
    reg_hit = (addr == idx);
  endfunction : reg_hit

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic [PIN_BITS-1:0] sync1_q;
  logic [PIN_BITS-1:0] sync2_q;
  logic [7:0] ad_s;
  logic [1:0] a_s;
  logic ale_s;
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic [DMA_CH-1:0] dack_s;
  always_ff @(posedge CLK) begin
    if (RST) begin
      sync1_q <= PIN_IDLE;
      sync2_q <= PIN_IDLE;
    end else begin
      sync1_q <= {AD_IN, ADDR_PIN, ALE, CS_N, RD_N, WR_N, DMA_GRANT_ACK};
      sync2_q <= sync1_q;
    end
  end
  assign ad_s = sync2_q[P_AD +: 8];
  assign a_s = sync2_q[P_A +: 2];
  assign ale_s = sync2_q[P_ALE];
  assign cs_n_s = sync2_q[P_CS];
  assign rd_n_s = sync2_q[P_RD];
  assign wr_n_s = sync2_q[P_WR];
  assign dack_s = sync2_q[P_DACK +: DMA_CH];

  // ----------------------------------------------------------------
  // Bus mode and address capture
  // ----------------------------------------------------------------
  logic ale_prev_q;
  logic mux_q;
  logic [7:0] ale_addr_q;
  logic ds_mode;
  logic access;
  logic is_read;
  logic [7:0] eff_addr;
  always_ff @(posedge CLK) begin
    if (RST) begin
      ale_prev_q <= 1'b0;
      mux_q <= 1'b0;
      ale_addr_q <= REG_RESET;
    end else begin
      ale_prev_q <= ale_s;
      if (ale_prev_q && !ale_s) begin
        mux_q <= 1'b1;
        ale_addr_q <= ad_s;
      end
    end
  end

  // A latch strobe held high during a strobe means the data-strobe style
  assign ds_mode = ale_s;
  assign access = !cs_n_s && (ds_mode ? !rd_n_s : (!rd_n_s || !wr_n_s));
  assign is_read = ds_mode ? wr_n_s : !rd_n_s;
  assign eff_addr = (mux_q && !ds_mode) ? ale_addr_q : {6'h00, a_s};

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  port_state_type state_q;
  port_state_type state_d;
  logic rd_go;
  logic wr_go;
  assign rd_go = (state_q == ST_IDLE) && access && is_read;
  assign wr_go = (state_q == ST_IDLE) && access && !is_read;
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (rd_go) begin
          state_d = ST_FETCH;
        end else if (wr_go) begin
          state_d = ST_HOLD;
        end
      end
      ST_FETCH: begin
        state_d = ST_HOLD;
      end
      ST_HOLD: begin
        if (!access) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Host registers
  // ----------------------------------------------------------------
  logic [7:0] addr_lo_q;
  logic [HI_BITS-1:0] addr_hi_q;
  logic dma_en_q;
  logic [CM_LOW_BITS-1:0] cm_low_hold_q;
  logic [PTR_BITS-1:0] ptr;
  logic ptr_ok;
  logic mem_wr;
  assign ptr = {addr_hi_q[HI_PTR8], addr_lo_q};
  assign ptr_ok = (32'(ptr) < DEPTH);
  assign mem_wr = wr_go && reg_hit(eff_addr, REG_MEM_DATA) && ptr_ok;
  always_ff @(posedge CLK) begin
    if (RST) begin
      addr_lo_q <= REG_RESET;
      addr_hi_q <= REG_RESET[HI_BITS-1:0];
      dma_en_q <= 1'b0;
      cm_low_hold_q <= REG_RESET;
    end else if (wr_go) begin
      if (reg_hit(eff_addr, REG_ADDR_LO)) begin
        addr_lo_q <= ad_s;
      end
      if (reg_hit(eff_addr, REG_ADDR_HI)) begin
        addr_hi_q <= ad_s[HI_BITS-1:0];
      end
      if (reg_hit(eff_addr, REG_CTRL)) begin
        dma_en_q <= ad_s[CTRL_DMA_EN];
      end
      if (mem_wr && addr_hi_q[HI_SEL_CM] && !addr_hi_q[HI_CM_HIGH]) begin
        cm_low_hold_q <= ad_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Memories: host port and fabric port
  // ----------------------------------------------------------------
  // Fabric writes land after the host write, so fresh samples win a collision
  always_ff @(posedge CLK) begin
    if (mem_wr && !addr_hi_q[HI_SEL_CM]) begin
      dm[ptr] <= ad_s;
    end
    if (SW_DM_WE && (32'(SW_DM_WADDR) < DEPTH)) begin
      dm[SW_DM_WADDR] <= SW_DM_WDATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (mem_wr && addr_hi_q[HI_SEL_CM] && addr_hi_q[HI_CM_HIGH]) begin
      cm[ptr] <= {ad_s[CM_HIGH_BITS-1:0], cm_low_hold_q};
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      SW_DM_Q <= '0;
      SW_CM_Q <= '0;
    end else begin
      SW_DM_Q <= (32'(SW_DM_RADDR) < DEPTH) ? dm[SW_DM_RADDR] : '0;
      SW_CM_Q <= (32'(SW_CM_RADDR) < DEPTH) ? cm[SW_CM_RADDR] : '0;
    end
  end

  // ----------------------------------------------------------------
  // DMA requests and error status
  // ----------------------------------------------------------------
  logic [DMA_CH-1:0] dreq_q;
  logic [DMA_CH-1:0] overrun_q;
  logic overrun_clr;
  assign overrun_clr = wr_go && reg_hit(eff_addr, REG_CTRL) && ad_s[CTRL_OVERRUN];

  generate
    for (genvar i = 0; i < DMA_CH; i++) begin : g_dma
      always_ff @(posedge CLK) begin
        if (RST || !dma_en_q) begin
          dreq_q[i] <= 1'b0;
        end else if (DMA_NEED[i]) begin
          dreq_q[i] <= 1'b1;
        end else if (dack_s[i]) begin
          dreq_q[i] <= 1'b0;
        end
      end

      // A new need while the last is still unanswered is an overrun
      always_ff @(posedge CLK) begin
        if (RST) begin
          overrun_q[i] <= 1'b0;
        end else if (dma_en_q && DMA_NEED[i] && dreq_q[i]) begin
          overrun_q[i] <= 1'b1;
        end else if (overrun_clr) begin
          overrun_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK) begin
    if (RST) begin
      DMA_TRANSFER_REQUEST <= '0;
      ERR <= 1'b0;
    end else begin
      DMA_TRANSFER_REQUEST <= dreq_q;
      ERR <= CLK4_LOST || PLL_UNLOCKED || (|overrun_q);
    end
  end

  // ----------------------------------------------------------------
  // Read data and pin drivers
  // ----------------------------------------------------------------
  logic [7:0] rd_value;
  logic [CM_BITS-1:0] cm_word;
  assign cm_word = ptr_ok ? cm[ptr] : '0;

  always_comb begin
    rd_value = REG_RESET;
    if (reg_hit(eff_addr, REG_ADDR_LO)) begin
      rd_value = addr_lo_q;
    end else if (reg_hit(eff_addr, REG_ADDR_HI)) begin
      rd_value[HI_BITS-1:0] = addr_hi_q;
    end else if (reg_hit(eff_addr, REG_CTRL)) begin
      rd_value[CTRL_DMA_EN] = dma_en_q;
      rd_value[CTRL_OVERRUN] = |overrun_q;
      rd_value[CTRL_CLK_LOST] = CLK4_LOST;
      rd_value[CTRL_PLL_UNLOCK] = PLL_UNLOCKED;
      rd_value[CTRL_MUX] = mux_q;
    end else if (reg_hit(eff_addr, REG_MEM_DATA) && ptr_ok) begin
      if (!addr_hi_q[HI_SEL_CM]) begin
        rd_value = dm[ptr];
      end else if (addr_hi_q[HI_CM_HIGH]) begin
        rd_value[CM_HIGH_BITS-1:0] = cm_word[CM_BITS-1:CM_LOW_BITS];
      end else begin
        rd_value = cm_word[CM_LOW_BITS-1:0];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      AD_OUT <= REG_RESET;
    end else if (state_q == ST_FETCH) begin
      AD_OUT <= rd_value;
    end
  end

  // Drive starts one cycle early with stale data; ready holds the host off it
  always_ff @(posedge CLK) begin
    if (RST) begin
      AD_OE <= 1'b0;
    end else begin
      AD_OE <= access && is_read && (state_d != ST_IDLE);
    end
  end

  // Open drain: the output is always low, the enable decides the level
  always_ff @(posedge CLK) begin
    if (RST) begin
      READY_OUT <= 1'b0;
      READY_OE <= 1'b0;
    end else begin
      READY_OUT <= 1'b0;
      READY_OE <= !cs_n_s && (ds_mode ? (access && (state_d == ST_HOLD))
        : (state_d == ST_FETCH));
    end
  end

endmodule : tdm_switch_host_port

// ==== sim/dma_ctrl_model.sv ====
// Model of the external DMA controller answering the request pins.
// Assumes active-high levels on one clock; each grant is an 8-cycle pulse.
`timescale 1ns/10ps
module dma_ctrl_model (
  // Clock
  input wire logic clk,
  // Handshake
  input wire logic [1:0] req,
  input wire logic [3:0] lag,
  output logic [1:0] ack
);
  // ------
  // Grant timing
  // ------
  logic [1:0] ack_q = 2'h0;
  logic [3:0] cnt_q [2] = '{4'h0, 4'h0};
  assign ack = ack_q;
  // A pulse, not a level: a request that never drops is answered again
  always @(posedge clk) begin
    for (int c = 0; c < 2; c++) begin
      cnt_q[c] <= cnt_q[c] + 4'h1;
      if (ack_q[c] && cnt_q[c] == 4'h7) begin
        ack_q[c] <= 1'b0;
        cnt_q[c] <= 4'h0;
      end else if (!ack_q[c] && (!req[c] || cnt_q[c] >= lag)) begin
        ack_q[c] <= req[c];
        cnt_q[c] <= 4'h0;
      end
    end
  end
endmodule : dma_ctrl_model

// ==== sim/tdm_switch_host_port_properties.sv ====
// Pin checker bound to the host port top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module tdm_host_port_checker (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Host pins
  input wire logic ALE,
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic AD_OE,
  input wire logic READY_OE,
  // Status and DMA
  input wire logic ERR,
  input wire logic CLK4_LOST,
  input wire logic PLL_UNLOCKED,
  input wire logic [tdm_host_pkg::DMA_CH-1:0] DMA_NEED,
  input wire logic [tdm_host_pkg::DMA_CH-1:0] DMA_TRANSFER_REQUEST
);
  import tdm_host_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // ------
  // Pin relations; windows allow for the two-flop input delay
  // ------
  property p_rst; $fell(RST) |-> !(AD_OE || READY_OE || ERR || |DMA_TRANSFER_REQUEST); endproperty
  a_rst: assert property (p_rst) else $error("not idle after reset");
  property p_err; CLK4_LOST || PLL_UNLOCKED |-> ##[1:2] ERR; endproperty
  a_err: assert property (p_err) else $error("error flag low");
  property p_cs; CS_N [*6] |-> !AD_OE && !READY_OE; endproperty
  a_cs: assert property (p_cs) else $error("pins held without select");
  property p_rd; (!CS_N && !RD_N && WR_N && !ALE) [*6] |-> AD_OE; endproperty
  a_rd: assert property (p_rd) else $error("read not driven");
  property p_wr; (!CS_N && RD_N && !WR_N && !ALE) [*6] |-> !AD_OE; endproperty
  a_wr: assert property (p_wr) else $error("write drove bus");
  property p_rdy; $rose(READY_OE) && !ALE && WR_N |=> !READY_OE; endproperty
  a_rdy: assert property (p_rdy) else $error("wait longer than one cycle");
  property p_dsw; (ALE && !CS_N && !RD_N && !WR_N) [*5] |-> READY_OE; endproperty
  a_dsw: assert property (p_dsw) else $error("no write acknowledge");
  property p_dsr; (ALE && !CS_N && !RD_N && WR_N) [*6] |-> AD_OE && READY_OE; endproperty
  a_dsr: assert property (p_dsr) else $error("no read acknowledge");
  property p_req; $rose(DMA_TRANSFER_REQUEST[0]) |-> $past(DMA_NEED[0], 2); endproperty
  a_req: assert property (p_req) else $error("request without need");
endmodule : tdm_host_port_checker

// ==== sim/tdm_switch_host_port_tb_top.sv ====
// Bench for the host port: scenario tasks, DMA controller model, pin checker.
// Assumes host pins move at the falling edge; the ready line has a pull-up.
`timescale 1ns/10ps
module tdm_switch_host_port_tb_top;
  import tdm_host_pkg::*;
  // ------
  // Pins and bench state
  // ------
  logic CLK = 1'b0, RST = 1'b1, ALE = 1'b0, CS_N = 1'b1, RD_N = 1'b1, WR_N = 1'b1;
  logic CLK4_LOST = 1'b0, PLL_UNLOCKED = 1'b0, SW_DM_WE = 1'b0, dsm = 1'b0, host_oe = 1'b0;
  logic [7:0] host_ad = 8'h00, SW_DM_WDATA = 8'h00, AD_OUT, SW_DM_Q, rdat;
  logic [8:0] SW_DM_WADDR = 9'h000, SW_DM_RADDR = 9'h000, SW_CM_RADDR = 9'h000;
  logic [1:0] ADDR_PIN = 2'h0, DMA_NEED = 2'h0, DMA_TRANSFER_REQUEST, DMA_GRANT_ACK;
  logic [11:0] SW_CM_Q;
  logic [3:0] lag = 4'h0;
  logic AD_OE, READY_OE, READY_OUT, ERR;
  // Undriven AD shows the inverse of the last value, so a stale byte never matches
  wire logic [7:0] AD_IN = AD_OE ? AD_OUT : host_oe ? host_ad : ~host_ad;
  wire logic ready_pin = READY_OE ? READY_OUT : 1'b1;
  int n_fail = 0, checked = 0;
  initial forever #20 CLK = ~CLK;
  tdm_switch_host_port DUT (.CLK, .RST, .AD_IN, .AD_OUT, .AD_OE, .ADDR_PIN, .ALE, .CS_N, .RD_N,
    .WR_N, .READY_OUT, .READY_OE, .ERR, .DMA_TRANSFER_REQUEST, .DMA_GRANT_ACK, .CLK4_LOST,
    .PLL_UNLOCKED, .DMA_NEED, .SW_DM_WE, .SW_DM_WADDR, .SW_DM_WDATA, .SW_DM_RADDR,
    .SW_CM_RADDR, .SW_DM_Q, .SW_CM_Q);
  dma_ctrl_model u_dma (.clk(CLK), .req(DMA_TRANSFER_REQUEST), .lag, .ack(DMA_GRANT_ACK));
  task automatic give_verdict;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic cmp_val(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_val({11'h000, got}, {11'h000, exp});
  endtask : cmp_bit
  task automatic stuck;
    n_fail++;
    $display("Error at %0t: wait ran out", $time);
    give_verdict();
  endtask : stuck
  // One host cycle, held two cycles past the answer (a plain write waits for none and holds six); a read leaves the wire byte in rdat
  task automatic access(input logic rd, input logic [1:0] a, input logic [7:0] d);
    int i;
    @(negedge CLK);
    {CS_N, ADDR_PIN, host_ad, host_oe, WR_N} = {1'b0, a, d, !rd, rd};
    RD_N = dsm ? 1'b0 : !rd;
    i = 0;
    if (rd || dsm) begin
      for (; i < 20 && ready_pin; i++) @(negedge CLK);
      for (; i < 20 && !ready_pin && !dsm; i++) @(negedge CLK);
      if (i == 20) stuck();
    end
    rdat = AD_IN;
    repeat ((rd || dsm) ? 2 : 6) @(negedge CLK);
    {CS_N, RD_N, WR_N, host_oe} = 4'he;
    for (i = 0; i < 20 && (AD_OE || READY_OE); i++) @(negedge CLK);
    if (i == 20) stuck();
    repeat (2) @(negedge CLK);
  endtask : access
  task automatic ptr(input logic [7:0] hi, input logic [7:0] lo);
    access(1'b0, 2'h0, lo);
    access(1'b0, 2'h1, hi);
  endtask : ptr
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
    access(1'b1, a, 8'h00);
    cmp_val({4'h0, rdat}, {4'h0, exp});
  endtask : rd_chk
  task automatic wait_req(input int ch, input logic lvl);
    int i;
    for (i = 0; i < 40 && DMA_TRANSFER_REQUEST[ch] !== lvl; i++) @(negedge CLK);
    if (i == 40) stuck();
  endtask : wait_req
  // Multiplexed cycle: address latched by the falling strobe, A pins left at 3
  task automatic mx(input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK);
    {ALE, host_oe, host_ad} = {1'b1, 1'b1, a};
    repeat (3) @(negedge CLK);
    ALE = 1'b0;
    repeat (3) @(negedge CLK);
    access(rd, 2'h3, d);
  endtask : mx
  // ------
  // Scenarios
  // ------
  task automatic t_reset;
    cmp_bit(AD_OE | READY_OE | ERR | |DMA_TRANSFER_REQUEST, 1'b0);
    rd_chk(2'h3, 8'h00);
    $display("reset done");
  endtask : t_reset
  task automatic t_mem;
    ptr(8'h01, 8'h7f);
    access(1'b0, 2'h2, 8'ha5);
    ptr(8'h00, 8'h05);
    access(1'b0, 2'h2, 8'h5a);
    ptr(8'h01, 8'h7f);
    rd_chk(2'h2, 8'ha5);
    SW_DM_RADDR = 9'h17f;
    ptr(8'h02, 8'h10);
    access(1'b0, 2'h2, 8'h3c);
    ptr(8'h06, 8'h10);
    access(1'b0, 2'h2, 8'h09);
    SW_CM_RADDR = 9'h010;
    ptr(8'h02, 8'h10);
    access(1'b0, 2'h2, 8'h55);
    cmp_val(SW_CM_Q, 12'h93c);
    cmp_val({4'h0, SW_DM_Q}, 12'h0a5);
    ptr(8'h06, 8'h10);
    rd_chk(2'h2, 8'h09);
    $display("memory done");
  endtask : t_mem
  task automatic t_fabric_cs;
    {SW_DM_WADDR, SW_DM_WDATA, SW_DM_WE} = {9'h007, 8'h77, 1'b1};
    @(negedge CLK);
    SW_DM_WE = 1'b0;
    ptr(8'h00, 8'h07);
    rd_chk(2'h2, 8'h77);
    ptr(8'h00, 8'h05);
    {ADDR_PIN, host_oe, host_ad, WR_N} = {2'h2, 1'b1, 8'hee, 1'b0};
    repeat (6) @(negedge CLK);
    {host_oe, WR_N, RD_N} = 3'b010;
    repeat (6) @(negedge CLK);
    cmp_bit(AD_OE | READY_OE, 1'b0);
    RD_N = 1'b1;
    rd_chk(2'h2, 8'h5a);
    $display("fabric and select done");
  endtask : t_fabric_cs
  task automatic t_err_dma;
    for (int k = 0; k < 2; k++) begin
      {PLL_UNLOCKED, CLK4_LOST} = (k == 1) ? 2'b10 : 2'b01;
      repeat (3) @(negedge CLK);
      cmp_bit(ERR, 1'b1);
      rd_chk(2'h3, (k == 1) ? 8'h08 : 8'h04);
      {PLL_UNLOCKED, CLK4_LOST} = 2'b00;
      repeat (3) @(negedge CLK);
      cmp_bit(ERR, 1'b0);
    end
    access(1'b0, 2'h3, 8'h01);
    for (int k = 0; k < 4; k++) begin
      lag = (k > 1) ? 4'h5 : 4'h0;
      DMA_NEED[k % 2] = 1'b1;
      @(negedge CLK);
      DMA_NEED = 2'h0;
      wait_req(k % 2, 1'b1);
      wait_req(k % 2, 1'b0);
    end
    lag = 4'hf;
    for (int k = 0; k < 2; k++) begin
      DMA_NEED = 2'h1;
      @(negedge CLK);
      DMA_NEED = 2'h0;
      repeat (2) @(negedge CLK);
    end
    cmp_bit(ERR, 1'b1);
    wait_req(0, 1'b0);
    rd_chk(2'h3, 8'h03);
    access(1'b0, 2'h3, 8'h02);
    DMA_NEED = 2'h3;
    @(negedge CLK);
    DMA_NEED = 2'h0;
    repeat (6) @(negedge CLK);
    cmp_bit(|DMA_TRANSFER_REQUEST | ERR, 1'b0);
    $display("error and dma done");
  endtask : t_err_dma
  task automatic t_rst2;
    access(1'b0, 2'h3, 8'h01);
    RST = 1'b1;
    repeat (4) @(negedge CLK);
    RST = 1'b0;
    repeat (2) @(negedge CLK);
    cmp_val(SW_CM_Q, 12'h93c);
    rd_chk(2'h3, 8'h00);
    $display("second reset done");
  endtask : t_rst2
  task automatic t_modes;
    {ALE, dsm} = 2'b11;
    ptr(8'h00, 8'h09);
    access(1'b0, 2'h2, 8'hc3);
    rd_chk(2'h2, 8'hc3);
    dsm = 1'b0;
    mx(1'b0, 8'h00, 8'h7f);
    mx(1'b0, 8'h01, 8'h01);
    mx(1'b1, 8'h02, 8'h00);
    cmp_val({4'h0, rdat}, 12'h0a5);
    mx(1'b1, 8'h03, 8'h00);
    cmp_val({4'h0, rdat}, 12'h010);
    $display("bus modes done");
  endtask : t_modes
  initial begin
    repeat (4) @(negedge CLK);
    RST = 1'b0;
    @(negedge CLK);
    t_reset();
    t_mem();
    t_fabric_cs();
    t_err_dma();
    t_rst2();
    t_modes();
    give_verdict();
  end
endmodule : tdm_switch_host_port_tb_top
bind tdm_switch_host_port tdm_host_port_checker u_chk (.CLK, .RST, .ALE, .CS_N, .RD_N, .WR_N,
  .AD_OE, .READY_OE, .ERR, .CLK4_LOST, .PLL_UNLOCKED, .DMA_NEED, .DMA_TRANSFER_REQUEST);
